// >>> rtl/interrupt_vector_priority_map.sv
`timescale 1ns/1ps
module interrupt_vector_priority_map #(
   parameter bit FLASH_VARIANT = 1'b1
) (
   // Clock and reset
   input wire logic CLK_SYS_IN,
   input wire logic RESET_N_IN,
   // Non-maskable sources
   input wire logic NMI_REQ_IN,
   input wire logic ADDR_BREAK_REQ_IN,
   // Peripheral causes and their enables
   input wire logic [ivpm_pkg::NUM_CAUSES-1:0] CAUSE_IN,
   input wire logic [ivpm_pkg::NUM_CAUSES-1:0] CAUSE_EN_IN,
   // Level select registers A..F, A in bits 7:0
   input wire logic [ivpm_pkg::LEVEL_BITS_W-1:0] LEVEL_SELECT_IN,
   input wire logic [1:0] GLOBAL_LEVEL_MASK_IN,
   input wire logic STATUS_I_IN,
   // CPU side
   input wire logic VEC_ACK_IN,
   output logic VEC_REQ_OUT,
   output logic [5:0] VEC_NUM_OUT,
   output logic [23:0] VEC_ADDR_OUT
);
   // ==========================================================
   // Level decode
   function automatic logic [1:0] eff_level(input logic [1:0] fld);
      eff_level = fld[1] ? 2'h2 : {1'b0, fld[0]};
   endfunction

   typedef enum logic [1:0] {
      ST_BOOT = 2'b01,
      ST_RUN = 2'b10
   } state_t;

   state_t state_reg;
   logic [ivpm_pkg::NUM_SRC-1:0] src_req;
   logic [ivpm_pkg::NUM_SRC-1:0] eligible;
   logic [1:0] src_lvl [ivpm_pkg::NUM_SRC];
   logic [1:0] min_lvl;
   logic sel_found;
   logic [1:0] sel_lvl;
   logic [5:0] sel_idx;
   logic [5:0] vec_next;
   logic req_next;
   logic tie_lower;

   // ==========================================================
   // Cause merging
   always_comb
   begin
      int base;
      base = 0;
      src_req = '0;
      for (int s = 0; s < ivpm_pkg::NUM_SRC; s++)
      begin
         for (int c = 0; c < ivpm_pkg::MAX_CAUSES_PER_SRC; c++)
         begin
            if (c < ivpm_pkg::SRC_CNT[s])
            begin
               src_req[s] = src_req[s] | (CAUSE_IN[base + c] & CAUSE_EN_IN[base + c]);
            end
         end
         base = base + ivpm_pkg::SRC_CNT[s];
      end
      if (!FLASH_VARIANT)
      begin
         src_req[ivpm_pkg::SRC_SERIAL4] = 1'b0;
      end
   end

   // ==========================================================
   // Per-source level and masking
   assign min_lvl = eff_level(GLOBAL_LEVEL_MASK_IN);

   genvar gs;
   generate
      for (gs = 0; gs < ivpm_pkg::NUM_SRC; gs++)
      begin : g_src
         localparam int FLD = ivpm_pkg::SRC_FLD[gs];
         localparam int BIT_HI = (FLD / 4) * 8 + 7 - 2 * (FLD % 4);
         // Shared fields give ch1 and ch2 one level each; the capture timer has a field of its own
         assign src_lvl[gs] = eff_level(LEVEL_SELECT_IN[BIT_HI -: 2]);
         assign eligible[gs] = src_req[gs] && !STATUS_I_IN && (src_lvl[gs] >= min_lvl);
      end
   endgenerate

   // ==========================================================
   // Arbitration
   // Descending scan with >= lets the lower slot win ties
   always_comb
   begin
      sel_found = 1'b0;
      sel_lvl = 2'h0;
      sel_idx = 6'h00;
      for (int s = ivpm_pkg::NUM_SRC - 1; s >= 0; s--)
      begin
         if (eligible[s] && (!sel_found || src_lvl[s] >= sel_lvl))
         begin
            sel_found = 1'b1;
            sel_lvl = src_lvl[s];
            sel_idx = 6'(s);
         end
      end
   end

   // Non-maskable sources always precede the arbitrated ones
   always_comb
   begin
      req_next = 1'b1;
      if (NMI_REQ_IN)
      begin
         vec_next = ivpm_pkg::VEC_NMI;
      end
      else if (ADDR_BREAK_REQ_IN)
      begin
         vec_next = ivpm_pkg::VEC_BREAK;
      end
      else
      begin
         vec_next = ivpm_pkg::SRC_VEC[sel_idx];
         req_next = sel_found;
      end
   end

   // ==========================================================
   // State
   // Boot holds the reset vector until the CPU takes it
   always_ff @(posedge CLK_SYS_IN)
   begin
      if (!RESET_N_IN)
      begin
         state_reg <= ST_BOOT;
      end
      else
      begin
         case (state_reg)
            ST_BOOT: if (VEC_ACK_IN) state_reg <= ST_RUN;
            ST_RUN: state_reg <= ST_RUN;
            default: state_reg <= ST_BOOT;
         endcase
      end
   end

   // ==========================================================
   // Outputs
   always_ff @(posedge CLK_SYS_IN)
   begin
      if (!RESET_N_IN)
      begin
         VEC_REQ_OUT <= 1'b1;
         VEC_NUM_OUT <= ivpm_pkg::VEC_RESET;
         VEC_ADDR_OUT <= {ivpm_pkg::ADDR_HI_ZERO, ivpm_pkg::VEC_RESET, ivpm_pkg::ADDR_LO_ZERO};
      end
      else if (state_reg == ST_RUN || VEC_ACK_IN)
      begin
         VEC_REQ_OUT <= req_next;
         VEC_NUM_OUT <= vec_next;
         VEC_ADDR_OUT <= {ivpm_pkg::ADDR_HI_ZERO, vec_next, ivpm_pkg::ADDR_LO_ZERO};
      end
   end

   // ==========================================================
   // Checks
   always_comb
   begin
      tie_lower = 1'b0;
      for (int s = 0; s < ivpm_pkg::NUM_SRC; s++)
      begin
         if (s < int'(sel_idx) && eligible[s] && src_lvl[s] == sel_lvl)
         begin
            tie_lower = 1'b1;
         end
      end
   end

   wire run = (state_reg == ST_RUN);

   reset_vector_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
      $rose(RESET_N_IN) |-> VEC_REQ_OUT && VEC_NUM_OUT == ivpm_pkg::VEC_RESET)
      else $error("reset vector not presented");
   nmi_vector_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
      run && NMI_REQ_IN |=> VEC_REQ_OUT && VEC_NUM_OUT == ivpm_pkg::VEC_NMI)
      else $error("nmi vector wrong");
   break_vector_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
      run && !NMI_REQ_IN && ADDR_BREAK_REQ_IN |=> VEC_NUM_OUT == ivpm_pkg::VEC_BREAK)
      else $error("address break vector wrong");
   tie_order_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
      sel_found |-> !tie_lower)
      else $error("tie not resolved by vector order");
   level_gate_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
      sel_found |-> sel_lvl >= eff_level(GLOBAL_LEVEL_MASK_IN) && sel_lvl != 2'h3)
      else $error("masked level selected");
   idisable_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
      run && STATUS_I_IN && !NMI_REQ_IN && !ADDR_BREAK_REQ_IN |=> !VEC_REQ_OUT)
      else $error("request passed while disabled");
   addr_scale_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
      VEC_ADDR_OUT == {ivpm_pkg::ADDR_HI_ZERO, VEC_NUM_OUT, ivpm_pkg::ADDR_LO_ZERO})
      else $error("vector address mismatch");
   ch1_vector_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
      run && !NMI_REQ_IN && !ADDR_BREAK_REQ_IN && eligible == (40'h1 << ivpm_pkg::SRC_CH1_A)
      |=> VEC_NUM_OUT == 6'h1D)
      else $error("ch1 compare a vector wrong");
   ch2_vector_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
      run && !NMI_REQ_IN && !ADDR_BREAK_REQ_IN && eligible == (40'h1 << ivpm_pkg::SRC_CH2_B)
      |=> VEC_NUM_OUT == 6'h21)
      else $error("ch2 compare b vector wrong");
   capture_merge_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
      src_req[ivpm_pkg::SRC_CAPTURE] == |(CAUSE_IN[ivpm_pkg::CAUSE_CAPTURE_LO +: 2]
      & CAUSE_EN_IN[ivpm_pkg::CAUSE_CAPTURE_LO +: 2]))
      else $error("capture timer merge wrong");
   serial4_gone_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
      !FLASH_VARIANT |-> !src_req[ivpm_pkg::SRC_SERIAL4])
      else $error("serial unit 4 present without flash");

   boot_exit_c: cover property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
      state_reg == ST_BOOT ##1 run);
   tie_seen_c: cover property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
      sel_found && $countones(eligible) > 1);
   nmi_over_c: cover property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
      run && NMI_REQ_IN && sel_found);
endmodule // interrupt_vector_priority_map

// >>> rtl/ivpm_pkg.sv
package ivpm_pkg;
   localparam int NUM_SRC = 40;
   localparam int NUM_CAUSES = 55;
   localparam int NUM_FIELDS = 24;
   localparam int LEVEL_BITS_W = 48;
   localparam int MAX_CAUSES_PER_SRC = 4;
   localparam logic [5:0] VEC_RESET = 6'h00;
   localparam logic [5:0] VEC_NMI = 6'h03;
   localparam logic [5:0] VEC_BREAK = 6'h05;
   localparam logic [15:0] ADDR_HI_ZERO = 16'h0000;
   localparam logic [1:0] ADDR_LO_ZERO = 2'h0;
   // Source slots used by checks
   localparam int SRC_CH1_A = 23;
   localparam int SRC_CH2_B = 27;
   localparam int SRC_SERIAL4 = 31;
   localparam int SRC_CAPTURE = 38;
   localparam int CAUSE_CAPTURE_LO = 50;
   // Vector number of each arbitrated slot, in fixed priority order
   localparam logic [5:0] SRC_VEC [NUM_SRC] = '{
      6'h06, 6'h07, 6'h08, 6'h09, 6'h0A, 6'h0B, 6'h0C, 6'h0D, 6'h0E, 6'h0F,
      6'h10, 6'h11, 6'h12, 6'h13, 6'h14, 6'h15, 6'h16, 6'h17, 6'h18, 6'h19,
      6'h1A, 6'h1B, 6'h1C, 6'h1D, 6'h1E, 6'h1F, 6'h20, 6'h21, 6'h22, 6'h23,
      6'h24, 6'h25, 6'h26, 6'h27, 6'h28, 6'h2A, 6'h2B, 6'h35, 6'h36, 6'h37};
   // Level field index: register A..F times four plus pair (upper pair first)
   localparam int SRC_FLD [NUM_SRC] = '{
      0, 1, 2, 3, 3, 4, 4, 4, 4, 4, 4, 4, 4, 5, 5, 5, 5, 5, 5, 5,
      5, 6, 7, 8, 8, 8, 9, 9, 9, 10, 10, 11, 12, 13, 14, 16, 17, 20, 21, 22};
   // Number of merged causes per slot
   localparam int SRC_CNT [NUM_SRC] = '{
      1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1,
      1, 1, 1, 1, 1, 1, 1, 1, 1, 2, 2, 4, 3, 3, 4, 1, 1, 1, 2, 3};
endpackage

// >>> verif/cpu_core_model.sv
`timescale 1ns/1ps
// ==========
// CPU side: takes the reset vector once, after a set delay
module cpu_core_model #(
   parameter int ACK_DELAY = 3
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic vec_req_in,
   input wire logic [5:0] vec_num_in,
   output logic vec_ack_out
);
   int wait_cnt;
   logic booted;
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         wait_cnt <= 0;
         booted <= 1'b0;
         vec_ack_out <= 1'b0;
      end
      else if (vec_ack_out)
      begin
         vec_ack_out <= 1'b0;
         booted <= 1'b1;
      end
      else if (!booted && vec_req_in && vec_num_in === 6'h00)
      begin
         // Slow fetch so the boot hold is visible
         if (wait_cnt == ACK_DELAY)
            vec_ack_out <= 1'b1;
         else
            wait_cnt <= wait_cnt + 1;
      end
   end
endmodule // cpu_core_model

// >>> verif/interrupt_vector_priority_map_test.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; \
   $display("Error t=%0t got %0h exp %0h", $time, (a), (b)); end end
module interrupt_vector_priority_map_test;
   // ==========
   // Stimulus and observation
   logic clk_sys, rst_n, nmi_req, brk_req;
   logic [ivpm_pkg::NUM_CAUSES-1:0] cause, cause_en;
   logic [ivpm_pkg::LEVEL_BITS_W-1:0] level_sel;
   logic [1:0] gmask;
   logic stat_i, ack, vreq, vreq_nf;
   logic [5:0] vnum;
   logic [23:0] vaddr;
   int err_count, checks;
   interrupt_vector_priority_map #(.FLASH_VARIANT(1'b1)) dut_u (.CLK_SYS_IN(clk_sys),
      .RESET_N_IN(rst_n), .NMI_REQ_IN(nmi_req), .ADDR_BREAK_REQ_IN(brk_req),
      .CAUSE_IN(cause), .CAUSE_EN_IN(cause_en), .LEVEL_SELECT_IN(level_sel),
      .GLOBAL_LEVEL_MASK_IN(gmask), .STATUS_I_IN(stat_i), .VEC_ACK_IN(ack),
      .VEC_REQ_OUT(vreq), .VEC_NUM_OUT(vnum), .VEC_ADDR_OUT(vaddr));
   interrupt_vector_priority_map #(.FLASH_VARIANT(1'b0)) dut_nf_u (.CLK_SYS_IN(clk_sys),
      .RESET_N_IN(rst_n), .NMI_REQ_IN(nmi_req), .ADDR_BREAK_REQ_IN(brk_req),
      .CAUSE_IN(cause), .CAUSE_EN_IN(cause_en), .LEVEL_SELECT_IN(level_sel),
      .GLOBAL_LEVEL_MASK_IN(gmask), .STATUS_I_IN(stat_i), .VEC_ACK_IN(ack),
      .VEC_REQ_OUT(vreq_nf), .VEC_NUM_OUT(), .VEC_ADDR_OUT());
   cpu_core_model #(.ACK_DELAY(3)) model_u (.clk_in(clk_sys), .rst_n_in(rst_n),
      .vec_req_in(vreq), .vec_num_in(vnum), .vec_ack_out(ack));
   // ==========
   // Shared tasks
   task automatic end_of_test;
      if (err_count == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic settle;
      repeat (2) @(posedge clk_sys);
      #1;
   endtask
   task automatic check_out(input logic r, input logic [5:0] v);
      `CHK(vreq, r)
      if (r)
      begin
         `CHK(vnum, v)
         `CHK(vaddr, {16'h0000, v, 2'h0})
      end
   endtask
   task automatic clear_all;
      {nmi_req, brk_req, stat_i, gmask} = 5'h00;
      cause = '0;
      cause_en = '0;
      level_sel = '0;
   endtask
   // ==========
   // Scenarios
   task automatic test_nmi_break;
      clear_all;
      {cause[0], cause_en[0], stat_i, gmask, level_sel[7:6]} = 7'h7F;
      settle;
      check_out(1'b0, 6'h00);
      {nmi_req, brk_req} = 2'h3;
      settle;
      check_out(1'b1, 6'h03);
      nmi_req = 1'b0;
      settle;
      check_out(1'b1, 6'h05);
   endtask
   task automatic test_mask_table;
      int fv, gm;
      clear_all;
      {cause[0], cause_en[0]} = 2'h3;
      for (fv = 0; fv < 4; fv++)
         for (gm = 0; gm < 4; gm++)
         begin
            level_sel[7:6] = fv[1:0];
            gmask = gm[1:0];
            settle;
            check_out(((fv > 1) ? 2 : fv) >= ((gm > 1) ? 2 : gm), 6'h06);
         end
   endtask
   task automatic test_timers;
      clear_all;
      gmask = 2'h1;
      {cause[25:23], cause_en[25:23], cause[0], cause_en[0]} = 8'hFF;
      {level_sel[7:6], level_sel[23:22]} = 4'h5;
      settle;
      check_out(1'b1, 6'h06);
      level_sel[23:22] = 2'h2;
      settle;
      check_out(1'b1, 6'h1D);
      {cause_en[25:23], cause_en[0]} = 4'h2;
      settle;
      check_out(1'b1, 6'h1D);
      cause_en[25:23] = 3'h6;
      settle;
      check_out(1'b1, 6'h1E);
      {cause[28:26], cause_en[28:26], level_sel[23:20]} = 10'h3F7;
      settle;
      check_out(1'b1, 6'h20);
      cause_en[26] = 1'b0;
      settle;
      check_out(1'b1, 6'h21);
      cause_en[28:23] = 6'h10;
      settle;
      check_out(1'b1, 6'h21);
   endtask
   task automatic test_merged;
      clear_all;
      {gmask, level_sel[45:44], cause[51:50]} = 6'h17;
      settle;
      check_out(1'b0, 6'h00);
      cause_en[51] = 1'b1;
      settle;
      check_out(1'b1, 6'h36);
      level_sel[45:44] = 2'h0;
      settle;
      check_out(1'b0, 6'h00);
      clear_all;
      {cause[35], cause_en[35]} = 2'h3;
      settle;
      check_out(1'b1, 6'h25);
      `CHK(vreq_nf, 1'b0)
   endtask
   // ==========
   // Clock, watchdog, main sequence
   initial
   begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   initial
   begin
      repeat (5000) @(posedge clk_sys);
      err_count++;
      end_of_test;
   end
   initial
   begin
      int k;
      {err_count, checks, rst_n} = '0;
      clear_all;
      repeat (16) @(posedge clk_sys);
      #1;
      check_out(1'b1, 6'h00);
      {rst_n, cause[0], cause_en[0]} = 3'h7;
      settle;
      check_out(1'b1, 6'h00);
      // Ack is looked at off the edge, once it has settled
      for (k = 0; k < 20 && ack !== 1'b1; k++)
      begin
         @(posedge clk_sys);
         #1;
      end
      settle;
      check_out(1'b1, 6'h06);
      test_nmi_break;
      test_mask_table;
      test_timers;
      test_merged;
      end_of_test;
   end
endmodule // interrupt_vector_priority_map_test
